/* src/dpram_port_pkg.sv */
// constants and types for the dual-port memory port controller
package dpram_port_pkg;

	localparam int ADDR_W = 14;
	localparam int DATA_W = 16;
	localparam int CNT_W  = 4;

	// register offsets, byte addresses on the bus
	localparam logic [7:0] OFS_CMD    = 8'h00;
	localparam logic [7:0] OFS_ADDR   = 8'h04;
	localparam logic [7:0] OFS_WDATA  = 8'h08;
	localparam logic [7:0] OFS_RDATA  = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_CFG    = 8'h14;

	// field positions
	localparam int STAT_RUN_BIT   = 0;
	localparam int STAT_IRQ_BIT   = 1;
	localparam int STAT_STALL_BIT = 2;
	localparam int STAT_OWN_BIT   = 3;
	localparam int CFG_INHIBIT_BIT = 0;

	// reset values
	localparam logic       CFG_INHIBIT_RST = 1'b1;
	localparam logic [13:0] ADDR_RST       = 14'h0000;
	localparam logic [15:0] DATA_RST       = 16'h0000;

	// timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int T_ACCESS_NS   = 55;
	localparam int T_HOLD_NS     = 25;
	localparam int ACCESS_CYC    = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC      = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		OP_MEM_RD = 2'b00,
		OP_MEM_WR = 2'b01,
		OP_SEM_RD = 2'b10,
		OP_SEM_WR = 2'b11
	} op_t;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_SETUP   = 2'b01,
		ST_STROBE  = 2'b11,
		ST_RELEASE = 2'b10
	} state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              mem_sel_n;
		logic              sem_sel_n;
		logic              rw_n;
		logic              oe_n;
		logic              dq_oe;
	} pins_t;

endpackage : dpram_port_pkg

/* src/dpram_port_ctrl.sv */
// host controller driving one port of a dual-port memory with semaphores
// Summary of operation
// RULE1: device flags later-settled port busy on match
// RULE2: device never drives both busy low
// RULE3: mode pin makes busy output or input
// RULE4: slave busy input low blocks port writes
// RULE5: master ignores writes where it drives busy
// RULE6: host stalls access while busy is low
// RULE7: slave busy pin tied high, low inhibits
// RULE8: busy of depth-expanded devices ANDed together
// RULE9: zero into free semaphore grants token
// RULE10: non-holder zero leaves semaphore unchanged
// RULE11: holder one passes token or frees
// RULE12: eight semaphores, bit0 written, all bits read
// RULE13: semaphore access: memory deselected, token select low
// RULE14: deselected port enters standby, selected full access
// RULE15: right write to 3ffe sets left flag
// RULE16: left access at 3ffe clears left flag (the model clears it on a left read of 3ffe only)
// RULE17: left write 3fff sets, right read clears
// RULE18: mailbox words remain ordinary memory
// RULE19: arbitration ignores read or write
// RULE20: semaphore read latched while select active
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
module dpram_port_ctrl
	import dpram_port_pkg::*;
#(
	parameter int BUSY_N  = 1,
	parameter int ACC_CYC = ACCESS_CYC,
	parameter int HLD_CYC = HOLD_CYC
) (
	input  wire logic              i_core_clk,
	input  wire logic              i_rst,
	input  wire logic              i_wb_cyc,
	input  wire logic              i_wb_stb,
	input  wire logic              i_wb_we,
	input  wire logic [7:0]        i_wb_adr,
	input  wire logic [3:0]        i_wb_sel,
	input  wire logic [31:0]       i_wb_dat,
	output logic                   o_wb_ack,
	output logic [31:0]            o_wb_dat,
	output logic [ADDR_W-1:0]      o_ram_addr,
	output logic                   o_mem_sel_n,
	output logic                   o_token_space_select_n,
	output logic                   o_rw_n,
	output logic                   o_oe_n,
	output logic [DATA_W-1:0]      o_ram_dq,
	output logic                   o_ram_dq_oe,
	input  wire logic [DATA_W-1:0] i_ram_dq,
	input  wire logic [BUSY_N-1:0] i_contention_flag_n,
	output logic                   o_wr_inhibit_n,
	input  wire logic              i_mailbox_irq_n
);

	localparam logic [CNT_W-1:0] ACC_LOAD = CNT_W'(ACC_CYC - 1);
	localparam logic [CNT_W-1:0] HLD_LOAD = CNT_W'(HLD_CYC - 1);
	localparam pins_t PINS_IDLE = '{addr: ADDR_RST, mem_sel_n: 1'b1, sem_sel_n: 1'b1,
		rw_n: 1'b1, oe_n: 1'b1, dq_oe: 1'b0};

	state_t             state_reg;
	state_t             state_next;
	pins_t              pins_reg;
	pins_t              pins_next;
	logic [CNT_W-1:0]   cnt_reg;
	logic [CNT_W-1:0]   cnt_next;
	op_t                op_reg;
	logic [ADDR_W-1:0]  addr_reg;
	logic [DATA_W-1:0]  wdata_reg;
	logic [DATA_W-1:0]  rdata_reg;
	logic               inhibit_reg;
	logic               stall_reg;
	logic               own_reg;
	logic               irq_reg;
	logic               ack_reg;
	logic [31:0]        dat_reg;
	logic               capture;

	// bus decode
	wire        wb_req   = i_wb_cyc && i_wb_stb && !ack_reg;
	// writes land on the edge that completes the handshake
	wire        wb_wr    = i_wb_cyc && i_wb_stb && ack_reg && i_wb_we;
	wire        wr_cmd   = wb_wr && (i_wb_adr == OFS_CMD) && i_wb_sel[0];
	wire        wr_addr  = wb_wr && (i_wb_adr == OFS_ADDR);
	wire        wr_wdata = wb_wr && (i_wb_adr == OFS_WDATA);
	wire        wr_cfg   = wb_wr && (i_wb_adr == OFS_CFG) && i_wb_sel[0];
	wire        start    = wr_cmd && (state_reg == ST_IDLE);
	wire [15:0] lane_dat = i_wb_dat[15:0];

	wire [ADDR_W-1:0] addr_next = {i_wb_sel[1] ? lane_dat[13:8] : addr_reg[13:8],
		i_wb_sel[0] ? lane_dat[7:0] : addr_reg[7:0]};
	wire [DATA_W-1:0] wdata_next = {i_wb_sel[1] ? lane_dat[15:8] : wdata_reg[15:8],
		i_wb_sel[0] ? lane_dat[7:0] : wdata_reg[7:0]};

	wire [31:0] status_word = {28'h0000000, own_reg, stall_reg, irq_reg,
		state_reg != ST_IDLE};
	wire [31:0] rd_mux =
		(i_wb_adr == OFS_CMD)    ? {30'h00000000, op_reg} :
		(i_wb_adr == OFS_ADDR)   ? {18'h00000, addr_reg} :
		(i_wb_adr == OFS_WDATA)  ? {16'h0000, wdata_reg} :
		(i_wb_adr == OFS_RDATA)  ? {16'h0000, rdata_reg} :
		(i_wb_adr == OFS_STATUS) ? status_word :
		(i_wb_adr == OFS_CFG)    ? {31'h00000000, inhibit_reg} : 32'h00000000;

	// port side decode
	wire busy_all_n = &i_contention_flag_n; // RULE8
	wire is_sem     = op_reg[1];
	wire is_wr      = op_reg[0];
	wire blocked    = !is_sem && !busy_all_n; // RULE6

	always_comb begin
		state_next = state_reg;
		pins_next  = pins_reg;
		cnt_next   = cnt_reg;
		capture    = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				pins_next = PINS_IDLE;
				if (start) begin
					state_next          = ST_SETUP;
					pins_next.addr      = addr_reg;
					pins_next.mem_sel_n = i_wb_dat[1]; // RULE13
					pins_next.sem_sel_n = !i_wb_dat[1]; // RULE13
					pins_next.dq_oe     = i_wb_dat[0];
				end
			end
			ST_SETUP: begin
				if (!blocked) begin // RULE6
					state_next      = ST_STROBE;
					pins_next.rw_n  = !is_wr;
					pins_next.oe_n  = is_wr;
					cnt_next        = ACC_LOAD;
				end
			end
			ST_STROBE: begin
				if (blocked) begin // RULE6
					state_next     = ST_SETUP;
					pins_next.rw_n = 1'b1;
					pins_next.oe_n = 1'b1;
				end else if (cnt_reg == '0) begin
					state_next     = ST_RELEASE;
					pins_next.rw_n = 1'b1;
					pins_next.oe_n = 1'b1; // RULE13
					cnt_next       = HLD_LOAD;
					capture        = !is_wr;
				end else begin
					cnt_next = cnt_reg - CNT_W'(1);
				end
			end
			ST_RELEASE: begin
				if (cnt_reg == '0) begin
					state_next = ST_IDLE;
					pins_next  = PINS_IDLE;
				end else begin
					cnt_next = cnt_reg - CNT_W'(1);
				end
			end
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state_reg <= ST_IDLE;
			pins_reg  <= PINS_IDLE;
			cnt_reg   <= '0;
		end else begin
			state_reg <= state_next;
			pins_reg  <= pins_next;
			cnt_reg   <= cnt_next;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			op_reg    <= OP_MEM_RD;
			addr_reg  <= ADDR_RST;
			wdata_reg <= DATA_RST;
		end else begin
			if (start)
				op_reg <= op_t'(i_wb_dat[1:0]);
			if (wr_addr)
				addr_reg <= addr_next;
			if (wr_wdata)
				wdata_reg <= wdata_next;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			rdata_reg <= DATA_RST;
			own_reg   <= 1'b0;
		end else if (capture) begin
			rdata_reg <= i_ram_dq;
			if (is_sem)
				own_reg <= !i_ram_dq[0];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			stall_reg   <= 1'b0;
			inhibit_reg <= CFG_INHIBIT_RST;
			irq_reg     <= 1'b0;
		end else begin
			if (start)
				stall_reg <= 1'b0;
			else if (state_reg == ST_SETUP && blocked)
				stall_reg <= 1'b1; // RULE8
			if (wr_cfg)
				inhibit_reg <= i_wb_dat[CFG_INHIBIT_BIT]; // RULE7
			irq_reg <= !i_mailbox_irq_n;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h00000000;
		end else begin
			ack_reg <= wb_req;
			if (wb_req)
				dat_reg <= rd_mux;
		end
	end

	assign o_wb_ack               = ack_reg;
	assign o_wb_dat               = dat_reg;
	assign o_ram_addr             = pins_reg.addr;
	assign o_mem_sel_n            = pins_reg.mem_sel_n;
	assign o_token_space_select_n = pins_reg.sem_sel_n;
	assign o_rw_n                 = pins_reg.rw_n;
	assign o_oe_n                 = pins_reg.oe_n;
	assign o_ram_dq_oe            = pins_reg.dq_oe;
	assign o_ram_dq               = wdata_reg;
	assign o_wr_inhibit_n         = inhibit_reg;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	// memory write strobe only after a free busy sample
	property p_wr_only_when_free;
		(!o_rw_n && !o_mem_sel_n) |-> $past(busy_all_n);
	endproperty
	a_wr_only_when_free: assert property (p_wr_only_when_free) // RULE6
		else $error("memory write strobed while busy was low");

	property p_stall_holds;
		(state_reg == ST_SETUP && blocked) |=> (state_reg == ST_SETUP && o_rw_n && o_oe_n);
	endproperty
	a_stall_holds: assert property (p_stall_holds) // RULE6
		else $error("access advanced while busy was low");

	property p_depth_and;
		(state_reg == ST_SETUP && !op_reg[1] && !(&i_contention_flag_n)) |=> stall_reg;
	endproperty
	a_depth_and: assert property (p_depth_and) // RULE8
		else $error("one low busy input did not stall");

	property p_inhibit_cfg;
		wr_cfg |=> (o_wr_inhibit_n == $past(i_wb_dat[CFG_INHIBIT_BIT]));
	endproperty
	a_inhibit_cfg: assert property (p_inhibit_cfg) // RULE7
		else $error("inhibit pin did not follow config write");

	property p_sem_space_select;
		!o_token_space_select_n |-> (o_mem_sel_n && (o_oe_n || o_rw_n));
	endproperty
	a_sem_space_select: assert property (p_sem_space_select) // RULE13
		else $error("token space selected with memory select low");

	sequence s_sem_rd_end;
		state_reg == ST_STROBE && cnt_reg == '0 && op_reg == OP_SEM_RD;
	endsequence
	sequence s_sem_released;
		(o_oe_n && !o_token_space_select_n) ##1 (o_oe_n && o_token_space_select_n);
	endsequence
	property p_sem_read_release;
		s_sem_rd_end |=> s_sem_released;
	endproperty
	a_sem_read_release: assert property (p_sem_read_release) // RULE13
		else $error("semaphore read not released after capture");

	property p_write_drives_data;
		!o_rw_n |-> (o_ram_dq_oe && o_oe_n);
	endproperty
	a_write_drives_data: assert property (p_write_drives_data) // RULE13
		else $error("write strobe without data drive");

	property p_wb_ack;
		(i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack ##1 !o_wb_ack;
	endproperty
	a_wb_ack: assert property (p_wb_ack)
		else $error("bus acknowledge not one cycle after request");

	// busy falling mid strobe of a memory access drops the strobe
	property p_strobe_drop;
		(state_reg == ST_STROBE && blocked) |=> (state_reg == ST_SETUP && o_rw_n && o_oe_n);
	endproperty
	a_strobe_drop: assert property (p_strobe_drop) // RULE6
		else $error("strobe kept while busy was low");

	// strobe starts only after a setup cycle
	property p_strobe_after_setup;
		($fell(o_rw_n) || $fell(o_oe_n)) |-> ($past(state_reg == ST_SETUP) && $stable(o_ram_addr));
	endproperty
	a_strobe_after_setup: assert property (p_strobe_after_setup) // RULE13
		else $error("strobe began without a setup cycle");

endmodule : dpram_port_ctrl

/* verif/dpram_dev_model.sv */
// behavioural device port model: memory, token latches, busy, mailbox
`timescale 1ns/100ps
module dpram_dev_model (
	input  wire logic [13:0] i_addr,
	input  wire logic        i_mem_sel_n,
	input  wire logic        i_tok_n,
	input  wire logic        i_rw_n,
	input  wire logic        i_oe_n,
	input  wire logic [15:0] i_dq,
	input  wire logic        i_inhibit_n,
	input  wire logic        i_match,
	input  wire logic        i_far_wr,
	input  wire logic        i_far_rd,
	input  wire logic [7:0]  i_far_req,
	output logic      [15:0] o_dq,
	output logic             o_busy_n,
	output logic             o_irq_n,
	output logic             o_far_irq_n
);
	logic [15:0] mem [0:16383];
	logic [7:0]  near_own = 8'h00;
	logic [7:0]  near_req = 8'h00;
	logic [7:0]  far_own = 8'h00;
	logic [15:0] tok_q = 16'hffff;
	logic [15:0] last = 16'h0000;
	wire         rd_mem = !i_mem_sel_n && !i_oe_n;
	wire         rd_tok = !i_tok_n && !i_oe_n;
	wire         wr_ok = o_busy_n && i_inhibit_n;
	wire  [2:0]  t = i_addr[2:0];
	initial o_irq_n = 1'b1;
	initial o_far_irq_n = 1'b1;
	task settle();
		near_own = near_own & near_req;
		far_own = far_own & i_far_req;
		near_own = near_own | (near_req & ~far_own);
		far_own = far_own | (i_far_req & ~near_own);
	endtask : settle
	assign o_busy_n = !(i_match && !i_mem_sel_n);
	assign o_dq = rd_mem ? mem[i_addr] : (rd_tok ? tok_q : ~last);
	always @(o_dq) if (rd_mem || rd_tok) last = o_dq;
	always @(posedge rd_tok) tok_q = {16{~near_own[t]}};
	always @(i_far_req) settle();
	always @(posedge i_rw_n) begin
		if (!i_mem_sel_n && wr_ok) begin
			mem[i_addr] = i_dq;
			if (i_addr == 14'h3fff) o_far_irq_n = 1'b0;
		end
		if (!i_tok_n) begin
			near_req[t] = !i_dq[0];
			settle();
		end
	end
	always @(posedge i_far_rd) o_far_irq_n = 1'b1;
	always @(posedge i_far_wr) o_irq_n = 1'b0;
	always @(posedge rd_mem) if (i_addr == 14'h3ffe) o_irq_n = 1'b1;
endmodule : dpram_dev_model

/* verif/dpram_port_ctrl_tb.sv */
// self-checking bench for the memory port controller
`timescale 1ns/100ps
module dpram_port_ctrl_tb;
	import dpram_port_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0, match = 1'b0, far_wr = 1'b0;
	logic        far_rd = 1'b0, far_irq_n;
	logic [7:0]  adr = 8'h00, far_req = 8'h00;
	logic [31:0] dat = 32'h0, got, rdat;
	logic [32:0] exp_q[$];
	logic [13:0] addr, a;
	logic [15:0] wdq, rdq, d;
	logic        ack, mem_n, tok_n, rw_n, oe_n, dq_oe, busy_n, inh_n, irq_n;
	int          seed = 36, bad_count = 0, n_tests = 0, cnt = 0;
	dpram_port_ctrl dpram_port_ctrl_i (.i_core_clk(clk), .i_rst(rst), .i_wb_cyc(cyc),
		.i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(dat),
		.o_wb_ack(ack), .o_wb_dat(rdat), .o_ram_addr(addr), .o_mem_sel_n(mem_n),
		.o_token_space_select_n(tok_n), .o_rw_n(rw_n), .o_oe_n(oe_n), .o_ram_dq(wdq),
		.o_ram_dq_oe(dq_oe), .i_ram_dq(rdq), .i_contention_flag_n(busy_n),
		.o_wr_inhibit_n(inh_n), .i_mailbox_irq_n(irq_n));
	dpram_dev_model dpram_dev_model_i (.i_addr(addr), .i_mem_sel_n(mem_n), .i_tok_n(tok_n),
		.i_rw_n(rw_n), .i_oe_n(oe_n), .i_dq(wdq), .i_inhibit_n(inh_n), .i_match(match),
		.i_far_wr(far_wr), .i_far_rd(far_rd), .i_far_req(far_req), .o_dq(rdq),
		.o_busy_n(busy_n), .o_irq_n(irq_n), .o_far_irq_n(far_irq_n));
	always #20 clk = ~clk;
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	always @(posedge clk) begin
		cnt++;
		if (cnt == 20000) begin
			bad_count++;
			stop_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	always @(posedge clk) if (ack === 1'b1 && we === 1'b0) begin
		if (exp_q[0][32]) chk("wb_read", exp_q[0][31:0], rdat);
		exp_q.pop_front();
	end
	task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] dt,
		input logic c, input logic [31:0] e);
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= ad;
		dat <= dt;
		if (!w) exp_q.push_back({c, e});
		do @(posedge clk); while (ack !== 1'b1);
		got = rdat;
		cyc <= 1'b0;
	endtask : bus
	task automatic rd(input logic [7:0] ad, input logic [31:0] e);
		bus(1'b0, ad, 32'h0, 1'b1, e);
	endtask : rd
	task automatic start(input logic [1:0] o, input logic [13:0] ad, input logic [15:0] dt);
		bus(1'b1, OFS_ADDR, {18'h0, ad}, 1'b0, 32'h0);
		bus(1'b1, OFS_WDATA, {16'h0, dt}, 1'b0, 32'h0);
		bus(1'b1, OFS_CMD, {30'h0, o}, 1'b0, 32'h0);
	endtask : start
	task automatic wait_idle();
		got = 32'h1;
		while (got[0]) bus(1'b0, OFS_STATUS, 32'h0, 1'b0, 32'h0);
	endtask : wait_idle
	task automatic op(input logic [1:0] o, input logic [13:0] ad, input logic [15:0] dt);
		start(o, ad, dt);
		wait_idle();
	endtask : op
	task automatic sem_rd(input logic [13:0] ad, input logic [31:0] e);
		op(OP_SEM_RD, ad, 16'h0);
		rd(OFS_RDATA, e);
	endtask : sem_rd
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		chk("wr_inhibit_n", 32'h1, {31'h0, inh_n});
		for (int i = 0; i < 3; i++) begin
			a = (i == 0) ? 14'($random(seed)) : 14'h3ffd + 14'(i);
			d = 16'($random(seed));
			op(OP_MEM_WR, a, d);
			op(OP_MEM_RD, a, 16'h0);
			rd(OFS_RDATA, {16'h0, d});
		end
		chk("far_irq_n", 32'h0, {31'h0, far_irq_n});
		far_rd <= 1'b1;
		@(posedge clk);
		far_rd <= 1'b0;
		chk("far_irq_n", 32'h1, {31'h0, far_irq_n});
		$display("test memory done");
		for (int s = 0; s < 8; s++) begin
			a = {11'($random(seed)), 3'(s)};
			op(OP_SEM_WR, a, 16'($random(seed)) & 16'hfffe);
			sem_rd(a, 32'h0);
			rd(OFS_STATUS, 32'h8);
			far_req[s] <= 1'b1;
			op(OP_SEM_WR, a, 16'($random(seed)) | 16'h1);
			sem_rd(a, 32'hffff);
			op(OP_SEM_WR, a, 16'h0);
			sem_rd(a, 32'hffff);
			far_req[s] <= 1'b0;
			sem_rd(a, 32'h0);
			op(OP_SEM_WR, a, 16'h1);
			sem_rd(a, 32'hffff);
		end
		$display("test token done");
		match <= 1'b1;
		d = 16'($random(seed));
		start(OP_MEM_WR, 14'h0123, d);
		repeat (6) @(posedge clk);
		rd(OFS_STATUS, 32'h5);
		match <= 1'b0;
		wait_idle();
		start(OP_MEM_RD, 14'h0123, 16'h0);
		@(posedge clk);
		match <= 1'b1;
		repeat (6) @(posedge clk);
		rd(OFS_STATUS, 32'h5);
		match <= 1'b0;
		wait_idle();
		rd(OFS_RDATA, {16'h0, d});
		bus(1'b1, OFS_CFG, 32'h0, 1'b0, 32'h0);
		@(posedge clk);
		chk("wr_inhibit_n", 32'h0, {31'h0, inh_n});
		op(OP_MEM_WR, 14'h0123, ~d);
		op(OP_MEM_RD, 14'h0123, 16'h0);
		rd(OFS_RDATA, {16'h0, d});
		bus(1'b1, OFS_CFG, 32'h1, 1'b0, 32'h0);
		@(posedge clk);
		chk("wr_inhibit_n", 32'h1, {31'h0, inh_n});
		$display("test busy done");
		far_wr <= 1'b1;
		repeat (3) @(posedge clk);
		far_wr <= 1'b0;
		rd(OFS_STATUS, 32'h2);
		op(OP_MEM_RD, 14'h3ffe, 16'h0);
		rd(OFS_STATUS, 32'h0);
		$display("test mailbox done");
		repeat (3) @(posedge clk);
		stop_test();
	end
endmodule : dpram_port_ctrl_tb
